/* hw/ree_pkg.sv */
// Constants and helpers for resolver encoder emulation.
package ree_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MAIN_OFS = 8'h08;
  localparam logic [7:0] AUX_OFS = 8'h0c;
  localparam logic [7:0] LADR_OFS = 8'h10;
  localparam logic [7:0] LDAT_OFS = 8'h14;
  localparam logic [7:0] ANG_OFS = 8'h18;
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_HSTD_BIT = 1;
  localparam int CTRL_CLRM_BIT = 2;
  localparam int CTRL_CLRA_BIT = 3;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int LUT_A = 0;
  localparam int LUT_B = 1;
  localparam int LUT_IDX = 2;
  localparam int LUT_HALL = 3;
  localparam int LUT_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] HALL_AT_ZERO = 3'h5;

  // Switch on reads as 1; index 0..3 means 10, 12, 14, 16 bits.
  function automatic logic [1:0] res_index(logic hi, logic lo);
    return {~hi, ~lo};
  endfunction

  // Emulation edge step as a shift of the left-aligned angle.
  function automatic logic [3:0] res_shift(logic [1:0] idx);
    case (idx)
      2'h0: return 4'h6;
      2'h1: return 4'h4;
      default: return 4'h2;
    endcase
  endfunction

  function automatic logic [15:0] ang_mask(logic [1:0] idx);
    case (idx)
      2'h0: return 16'hffc0;
      2'h1: return 16'hfff0;
      2'h2: return 16'hfffc;
      default: return 16'hffff;
    endcase
  endfunction

  // Phase 0..3 walks 00, A, AB, B so that A leads B going forward.
  function automatic logic [1:0] quad_phase(logic b, logic a);
    return {b, a ^ b};
  endfunction

  function automatic logic [2:0] hall_of(logic [2:0] sector);
    case (sector)
      3'h0: return HALL_AT_ZERO;
      3'h1: return 3'h4;
      3'h2: return 3'h6;
      3'h3: return 3'h2;
      3'h4: return 3'h3;
      default: return 3'h1;
    endcase
  endfunction
endpackage

/* hw/ree_quad_emu.sv */
// Quadrature A/B generator that tracks the converter angle edge by edge.
`timescale 1ns/10ps
module ree_quad_emu (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] angle,
  input wire logic [3:0] shift,
  output logic enc_a,
  output logic enc_b,
  output logic at_zero
);
  logic [15:0] cnt_q, cnt_d, step, tgt, diff;
  logic [1:0] ph;

  always_comb begin
    step = 16'h1 << shift;
    tgt = angle & ~(step - 16'h1);
    diff = tgt - cnt_q;
    cnt_d = cnt_q;
    // One edge per clock, so a fast jump never skips a quadrature state.
    if (diff != 16'h0) begin
      cnt_d = diff[15] ? cnt_q - step : cnt_q + step;
    end
    ph = 2'(cnt_d >> shift);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0;
      enc_a <= 1'b0;
      enc_b <= 1'b0;
      at_zero <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      enc_a <= ph[0] ^ ph[1];
      enc_b <= ph[1];
      at_zero <= (cnt_d == 16'h0);
    end
  end

  property p_quad;
    @(posedge aclk) disable iff (!aresetn)
      !($changed(enc_a) && $changed(enc_b));
  endproperty
  a_quad: assert property (p_quad)
    else $error("A and B changed together");
endmodule

/* hw/ree_pos_cnt.sv */
// Position counter for quadrature or pulse and direction input.
`timescale 1ns/10ps
module ree_pos_cnt (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic pd_mode,
  input wire logic in_a,
  input wire logic in_b,
  output logic [31:0] cnt
);
  logic [31:0] cnt_d, delta;
  logic pa_q, pb_q;
  logic [1:0] step;

  always_comb begin
    delta = 32'h0;
    step = ree_pkg::quad_phase(in_b, in_a)
         - ree_pkg::quad_phase(pb_q, pa_q);
    if (pd_mode) begin
      if (in_a && !pa_q) begin
        delta = in_b ? 32'h2 : 32'hffff_fffe;
      end
    end else if (step == 2'h1) begin
      delta = 32'h1;
    end else if (step == 2'h3) begin
      delta = 32'hffff_ffff;
    end
    cnt_d = clr ? 32'h0 : cnt + delta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 32'h0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      cnt <= cnt_d;
      pa_q <= in_a;
      pb_q <= in_b;
    end
  end

  property p_qcnt;
    @(posedge aclk) disable iff (!aresetn)
      (!pd_mode && !clr && (in_a != pa_q) && (in_b == pb_q))
      |=> (cnt - $past(cnt)) inside {32'h1, 32'hffff_ffff};
  endproperty
  a_qcnt: assert property (p_qcnt)
    else $error("quadrature edge did not move count by one");

  property p_pd;
    @(posedge aclk) disable iff (!aresetn)
      (pd_mode && !clr && in_a && !pa_q && in_b)
      |=> cnt == $past(cnt) + 32'h2;
  endproperty
  a_pd: assert property (p_pd)
    else $error("pulse did not add two counts");
endmodule

/* hw/ree_top.sv */
// Resolver encoder emulation with position counters and AXI4-Lite access.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module ree_top #(
  parameter int LUT_AW = 10,
  parameter logic [1:0] CUSTOM_RES_IDX = 2'h1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] angle_word,
  input wire logic resolution_select_hi,
  input wire logic resolution_select_lo,
  input wire logic emulation_source_switch,
  input wire logic aux_a,
  input wire logic aux_b,
  output logic [1:0] conv_res_sel,
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic [2:0] hall
);
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } ree_rd_e;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // The converter word should be latched by the converter while read;
  // a word caught mid-update is corrected on the next sample.
  logic [15:0] ang_s1_q, ang_s2_q;
  logic [2:0] sw_s1_q, sw_s2_q;
  logic [1:0] aux_s1_q, aux_s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ang_s1_q <= 16'h0;
      ang_s2_q <= 16'h0;
      sw_s1_q <= 3'h0;
      sw_s2_q <= 3'h0;
      aux_s1_q <= 2'h0;
      aux_s2_q <= 2'h0;
    end else begin
      ang_s1_q <= angle_word;
      ang_s2_q <= ang_s1_q;
      sw_s1_q <= {emulation_source_switch, resolution_select_hi,
                  resolution_select_lo};
      sw_s2_q <= sw_s1_q;
      aux_s1_q <= {aux_b, aux_a};
      aux_s2_q <= aux_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Resolution, angle and emulation sources
  // ------------------------------------------------------------------
  logic [1:0] res_idx_q, res_idx_d;
  logic [15:0] ang_m;
  logic [2:0] sector;
  logic [18:0] sect_prod;
  logic emu_a, emu_b, emu_zero;
  localparam int LUT_W_T = ree_pkg::LUT_W;
  logic [LUT_W_T-1:0] lut_word_q;
  logic [LUT_W_T-1:0] lut_mem [2**LUT_AW];
  logic [1:0] ctrl_q, ctrl_d;
  logic clr_main_q, clr_main_d, clr_aux_q, clr_aux_d;
  logic [LUT_AW-1:0] ladr_q, ladr_d;
  logic lut_we;
  logic enc_a_d, enc_b_d, idx_d;
  logic [2:0] hall_d;

  always_comb begin
    // The lookup contents are built for one resolution only.
    res_idx_d = sw_s2_q[2] ? CUSTOM_RES_IDX
                : ree_pkg::res_index(sw_s2_q[1], sw_s2_q[0]);
    ang_m = ang_s2_q & ree_pkg::ang_mask(res_idx_q);
    sect_prod = 19'(ang_m) * 19'h6;
    sector = sect_prod[18:16];
    if (sw_s2_q[2]) begin
      enc_a_d = lut_word_q[ree_pkg::LUT_A];
      enc_b_d = lut_word_q[ree_pkg::LUT_B];
      idx_d = lut_word_q[ree_pkg::LUT_IDX];
    end else begin
      enc_a_d = emu_a;
      enc_b_d = emu_b;
      idx_d = emu_zero;
    end
    if (ctrl_q[ree_pkg::CTRL_HSTD_BIT]) begin
      hall_d = ree_pkg::hall_of(sector);
    end else begin
      hall_d = lut_word_q[ree_pkg::LUT_HALL +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_idx_q <= 2'h0;
      conv_res_sel <= 2'h0;
      enc_a <= 1'b0;
      enc_b <= 1'b0;
      enc_index <= 1'b0;
      hall <= 3'h0;
      lut_word_q <= '0;
    end else begin
      res_idx_q <= res_idx_d;
      conv_res_sel <= res_idx_q;
      enc_a <= enc_a_d;
      enc_b <= enc_b_d;
      enc_index <= idx_d;
      hall <= hall_d;
      lut_word_q <= lut_mem[ang_m[15 -: LUT_AW]];
    end
  end

  always_ff @(posedge aclk) begin
    if (lut_we) begin
      lut_mem[ladr_q] <= wdat_d[LUT_W_T-1:0];
    end
  end

  ree_quad_emu u_emu (
    .aclk(aclk),
    .aresetn(aresetn),
    .angle(ang_m),
    .shift(ree_pkg::res_shift(res_idx_q)),
    .enc_a(emu_a),
    .enc_b(emu_b),
    .at_zero(emu_zero)
  );

  // ------------------------------------------------------------------
  // Position counters
  // ------------------------------------------------------------------
  logic [31:0] main_cnt, aux_cnt;

  // Counts the pair that leaves the pins, so software sees the same
  // position as an external encoder input would.
  ree_pos_cnt u_main (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clr_main_q),
    .pd_mode(1'b0),
    .in_a(enc_a),
    .in_b(enc_b),
    .cnt(main_cnt)
  );

  ree_pos_cnt u_aux (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clr_aux_q),
    .pd_mode(ctrl_q[ree_pkg::CTRL_PD_BIT]),
    .in_a(aux_s2_q[0]),
    .in_b(aux_s2_q[1]),
    .cnt(aux_cnt)
  );

  // ------------------------------------------------------------------
  // AXI4-Lite write side
  // ------------------------------------------------------------------
  logic awh_q, awh_d, wh_q, wh_d, bvalid_d, awready_d, wready_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdat_q, wdat_d;
  logic [1:0] bresp_d;
  logic do_wr;
  logic wst0_q, wst0_d;

  always_comb begin
    awh_d = awh_q | (s_axi_awvalid & s_axi_awready);
    wh_d = wh_q | (s_axi_wvalid & s_axi_wready);
    waddr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : waddr_q;
    wdat_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdat_q;
    // The strobe travels with the data beat, which may come first.
    wst0_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wst0_q;
    bvalid_d = s_axi_bvalid & ~s_axi_bready;
    bresp_d = s_axi_bresp;
    ctrl_d = ctrl_q;
    ladr_d = ladr_q;
    clr_main_d = 1'b0;
    clr_aux_d = 1'b0;
    lut_we = 1'b0;
    do_wr = awh_d & wh_d & ~s_axi_bvalid;
    if (do_wr) begin
      awh_d = 1'b0;
      wh_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ree_pkg::RESP_OKAY;
      case (waddr_d)
        ree_pkg::CTRL_OFS: begin
          if (wst0_d) begin
            ctrl_d = wdat_d[1:0];
            clr_main_d = wdat_d[ree_pkg::CTRL_CLRM_BIT];
            clr_aux_d = wdat_d[ree_pkg::CTRL_CLRA_BIT];
          end
        end
        ree_pkg::LADR_OFS: begin
          if (wst0_d) begin
            ladr_d = wdat_d[LUT_AW-1:0];
          end
        end
        ree_pkg::LDAT_OFS: lut_we = wst0_d;
        ree_pkg::STAT_OFS, ree_pkg::MAIN_OFS, ree_pkg::AUX_OFS,
        ree_pkg::ANG_OFS: bresp_d = ree_pkg::RESP_OKAY;
        default: bresp_d = ree_pkg::RESP_SLVERR;
      endcase
    end
    awready_d = ~awh_d & ~bvalid_d;
    wready_d = ~wh_d & ~bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_q <= 1'b0;
      wh_q <= 1'b0;
      waddr_q <= 8'h0;
      wdat_q <= 32'h0;
      wst0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_q <= ree_pkg::CTRL_RST;
      ladr_q <= '0;
      clr_main_q <= 1'b0;
      clr_aux_q <= 1'b0;
    end else begin
      awh_q <= awh_d;
      wh_q <= wh_d;
      waddr_q <= waddr_d;
      wdat_q <= wdat_d;
      wst0_q <= wst0_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      ctrl_q <= ctrl_d;
      ladr_q <= ladr_d;
      clr_main_q <= clr_main_d;
      clr_aux_q <= clr_aux_d;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read side
  // ------------------------------------------------------------------
  ree_rd_e rd_q, rd_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;

  always_comb begin
    rd_d = rd_q;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    unique case (rd_q)
      RD_IDLE: begin
        // Ready is still low on the first edge after reset.
        if (s_axi_arvalid && s_axi_arready) begin
          rd_d = RD_DATA;
          rresp_d = ree_pkg::RESP_OKAY;
          case (s_axi_araddr)
            ree_pkg::CTRL_OFS: rdata_d = {30'h0, ctrl_q};
            ree_pkg::STAT_OFS: rdata_d = {27'h0, res_idx_q, sw_s2_q};
            ree_pkg::MAIN_OFS: rdata_d = main_cnt;
            ree_pkg::AUX_OFS: rdata_d = aux_cnt;
            ree_pkg::LADR_OFS: rdata_d = 32'(ladr_q);
            ree_pkg::LDAT_OFS: rdata_d = 32'(lut_mem[ladr_q]);
            ree_pkg::ANG_OFS: rdata_d = {16'h0, ang_m};
            default: begin
              rdata_d = 32'h0;
              rresp_d = ree_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_d = RD_IDLE;
        end
      end
      default: rd_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= RD_IDLE;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      rd_q <= rd_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      s_axi_rvalid <= (rd_d == RD_DATA);
      s_axi_arready <= (rd_d == RD_IDLE);
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_main_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ree_pkg::MAIN_OFS;
  endsequence
  sequence s_aux_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ree_pkg::AUX_OFS;
  endsequence

  property p_res;
    @(posedge aclk) disable iff (!aresetn)
      !sw_s2_q[2] |=> res_idx_q ==
        ree_pkg::res_index($past(sw_s2_q[1]), $past(sw_s2_q[0]));
  endproperty
  a_res: assert property (p_res)
    else $error("resolution does not follow switches");

  property p_cust;
    @(posedge aclk) disable iff (!aresetn)
      sw_s2_q[2] |=> res_idx_q == CUSTOM_RES_IDX ##1
        conv_res_sel == CUSTOM_RES_IDX;
  endproperty
  a_cust: assert property (p_cust)
    else $error("resolution not fixed in lookup mode");

  property p_lut_ab;
    @(posedge aclk) disable iff (!aresetn)
      sw_s2_q[2] |=> enc_a == $past(lut_word_q[ree_pkg::LUT_A]) &&
        enc_b == $past(lut_word_q[ree_pkg::LUT_B]);
  endproperty
  a_lut_ab: assert property (p_lut_ab)
    else $error("A/B not from lookup");

  property p_lut_idx;
    @(posedge aclk) disable iff (!aresetn)
      sw_s2_q[2] |=> enc_index == $past(lut_word_q[ree_pkg::LUT_IDX]);
  endproperty
  a_lut_idx: assert property (p_lut_idx)
    else $error("index not from lookup");

  property p_hall0;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_q[ree_pkg::CTRL_HSTD_BIT] && ang_m == 16'h0
      |=> hall == ree_pkg::HALL_AT_ZERO;
  endproperty
  a_hall0: assert property (p_hall0)
    else $error("standard hall wrong at angle zero");

  property p_main;
    @(posedge aclk) disable iff (!aresetn)
      s_main_rd |=> s_axi_rvalid && s_axi_rdata == $past(main_cnt);
  endproperty
  a_main: assert property (p_main)
    else $error("main position read wrong");

  property p_aux;
    @(posedge aclk) disable iff (!aresetn)
      s_aux_rd |=> s_axi_rvalid && s_axi_rdata == $past(aux_cnt);
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux position read wrong");
endmodule

/* verif/ree_conv_model.sv */
// Converter and auxiliary encoder model that feeds the block's inputs.
`timescale 1ns/10ps
module ree_conv_model (
  input wire logic aclk,
  input wire logic [1:0] conv_res_sel,
  output logic [15:0] angle_word,
  output logic aux_a,
  output logic aux_b
);
  logic [1:0] ph = 2'h0;

  initial begin
    angle_word = 16'h0000;
    aux_a = 1'b0;
    aux_b = 1'b0;
  end

  task automatic set_angle(input logic [15:0] v);
    @(posedge aclk);
    angle_word <= v;
  endtask

  // Steps of one converter LSB every four clocks keep the tracking rate
  // well inside what the emulator follows, at every resolution.
  task automatic move_to(input logic [15:0] v);
    int sh;
    sh = 6 - 2 * int'(conv_res_sel);
    if (sh < 0) sh = 0;
    forever begin
      repeat (4) @(posedge aclk);
      if (angle_word == v) break;
      if (angle_word < v) angle_word <= angle_word + (16'h0001 << sh);
      else angle_word <= angle_word - (16'h0001 << sh);
    end
  endtask

  // A leads B when n is positive.
  task automatic aux_quad(input int n);
    for (int i = 0; i < (n < 0 ? -n : n); i++) begin
      ph = (n > 0) ? ph + 2'h1 : ph - 2'h1;
      @(posedge aclk);
      aux_a <= ^ph;
      aux_b <= ph[1];
      repeat (3) @(posedge aclk);
    end
  endtask

  task automatic aux_pulse(input int n, input logic up);
    @(posedge aclk);
    aux_a <= 1'b0;
    aux_b <= up;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      aux_a <= 1'b1;
      repeat (4) @(posedge aclk);
      aux_a <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule

/* verif/resolver_encoder_emulation_test.sv */
// Self-checking bench for the resolver encoder emulation block.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
  bad_count++; end end
module resolver_encoder_emulation_test;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp, conv_res_sel;
  logic hi = 1'b1, lo = 1'b1, src = 1'b0, pa = 1'b0, pb = 1'b0;
  logic aux_a, aux_b, enc_a, enc_b, enc_index;
  logic [2:0] hall;
  logic [15:0] angle_word;
  int bad_count = 0, tests_run = 0;

  always #5 aclk = ~aclk;

  ree_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .angle_word(angle_word), .resolution_select_hi(hi),
    .resolution_select_lo(lo), .emulation_source_switch(src),
    .aux_a(aux_a), .aux_b(aux_b), .conv_res_sel(conv_res_sel),
    .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index), .hall(hall));

  ree_conv_model u_conv (.aclk(aclk), .conv_res_sel(conv_res_sel),
    .angle_word(angle_word), .aux_a(aux_a), .aux_b(aux_b));

  // A double change would hide a step from any counter downstream.
  always @(posedge aclk) begin
    if (aresetn && enc_a !== pa && enc_b !== pb) begin
      $display("ERROR enc_ab expected one change seen two");
      bad_count++;
    end
    pa <= enc_a;
    pb <= enc_b;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 99);
    bready <= 1'b0;
    resp = bresp;
    `CHK("bvalid", 1'b1, bvalid)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 99);
    rready <= 1'b0;
    v = rdata;
    resp = rresp;
    `CHK("rvalid", 1'b1, rvalid)
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    `CHK("rdata", e, d)
  endtask

  task automatic t_regs();
    rc(8'h00, 32'h2);
    rc(8'h08, 32'h0);
    rc(8'h0c, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    `CHK("bresp", ree_pkg::RESP_OKAY, resp)
    rd(8'h1c, d);
    `CHK("rresp", ree_pkg::RESP_SLVERR, resp)
    `CHK("rdata", 32'h0, d)
    wr(8'h1c, 32'h1);
    `CHK("bresp", ree_pkg::RESP_SLVERR, resp)
    wr(8'h10, 32'hffff_ffff);
    rc(8'h10, 32'h3ff);
    wstrb <= 4'h0;
    wr(8'h10, 32'h0);
    wstrb <= 4'hf;
    `CHK("bresp", ree_pkg::RESP_OKAY, resp)
    rc(8'h10, 32'h3ff);
    $display("test regs done");
  endtask

  task automatic t_res();
    logic [15:0] m [4];
    m = '{16'hffc0, 16'hfff0, 16'hfffc, 16'hffff};
    for (int i = 0; i < 4; i++) begin
      hi <= ~i[1];
      lo <= ~i[0];
      repeat (8) @(posedge aclk);
      `CHK("res_sel", i[1:0], conv_res_sel)
      u_conv.set_angle(16'h5555);
      repeat (6) @(posedge aclk);
      rc(8'h18, {16'h0, 16'h5555 & m[i]});
      // Switches only move at angle zero, where A/B sit at rest.
      u_conv.set_angle(16'h0000);
      repeat (40) @(posedge aclk);
    end
    $display("test res done");
  endtask

  task automatic t_count();
    for (int i = 0; i < 4; i++) begin
      hi <= ~i[1];
      lo <= ~i[0];
      // Let the new resolution settle before trusting any position.
      repeat (20) @(posedge aclk);
      `CHK("index", 1'b1, enc_index)
      `CHK("hall", ree_pkg::HALL_AT_ZERO, hall)
      wr(8'h00, 32'h6);
      u_conv.move_to(16'h0400);
      repeat (40) @(posedge aclk);
      rc(8'h08, 32'h0400 >> ((i == 3) ? 2 : 6 - 2 * i));
      u_conv.move_to(16'h0000);
      repeat (40) @(posedge aclk);
      rc(8'h08, 32'h0);
    end
    $display("test count done");
  endtask

  task automatic t_lut();
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h1d);
    wr(8'h00, 32'h0);
    // The lookup must hold data before the switch hands it the pins.
    src <= 1'b1;
    hi <= 1'b1;
    lo <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK("res_sel", 2'h1, conv_res_sel)
    rc(8'h14, 32'h1d);
    `CHK("lut_out", 6'h1d, {hall, enc_index, enc_b, enc_a})
    src <= 1'b0;
    wr(8'h00, 32'h2);
    $display("test lut done");
  endtask

  task automatic t_aux();
    wr(8'h00, 32'ha);
    u_conv.aux_quad(12);
    repeat (10) @(posedge aclk);
    rc(8'h0c, 32'hc);
    wr(8'h00, 32'hb);
    u_conv.aux_pulse(5, 1'b1);
    rc(8'h0c, 32'ha);
    u_conv.aux_pulse(3, 1'b0);
    rc(8'h0c, 32'h4);
    $display("test aux done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_res();
    t_count();
    t_lut();
    t_aux();
    tally_and_finish();
  end
endmodule
